// >>> dv/ddr3_link_monitor.sv
// Concurrent checks on the link pins between controller end and DRAM end
`timescale 1ns/100ps
`default_nettype none
module ddr3_link_monitor
(
	input wire logic                                sys_rst,
	input wire logic                                ck,
	input wire logic                                cke,
	input wire logic                                odt,
	input wire logic [3:0]                          cmd_n,
	input wire logic [ddr3_link_pkg::BA_W-1:0]      ba,
	input wire logic [ddr3_link_pkg::A_W-1:0]       addr,
	input wire logic [2*ddr3_link_pkg::DQ_W-1:0]    dq_o,
	input wire logic                                dq_oe,
	input wire logic [1:0]                          dqs_o,
	input wire logic                                dqs_oe
);
	import ddr3_link_pkg::*;

	logic [9:0] zq_left;

	// Falling CK sees each data cycle mid-way, off the DRAM output update,
	// and each command at the end of its window, on the edge that launches the next
	default clocking mon_cb @(negedge ck);
	endclocking
	default disable iff (sys_rst);

	// One cycle short of the controller's wait, so a legal command at
	// the exact end of the window is not flagged
	always_ff @(negedge ck or posedge sys_rst)
	begin
		if (sys_rst)
			zq_left <= 10'h000;
		else if (cke && cmd_n == CMD_ZQ)
			zq_left <= addr[A10_BIT] ? 10'h1FF : 10'h03F;
		else if (zq_left != 10'h000)
			zq_left <= zq_left - 10'h001;
	end

	sequence rd_cmd;
		cke && cmd_n == CMD_RD;
	endsequence
	sequence col_cmd;
		cke && (cmd_n == CMD_RD || cmd_n == CMD_WR);
	endsequence
	sequence data_cycle;
		dq_oe && dqs_oe && dqs_o == DQS_DATA;
	endsequence

	a_read_latency: assert property (rd_cmd |-> ##5 data_cycle ##0
		(dq_o[7:0] == $past(addr[7:0], 5)))
		else $error("first read beat missing or wrong at RL");
	a_beat_order: assert property (rd_cmd |-> ##5
		(dq_o[15:8] == {$past(addr[7:2], 5), $past(addr[1:0], 5) + 2'h1}))
		else $error("second read beat out of order");
	a_burst_full: assert property (rd_cmd ##0 addr[A12_BIT] |->
		##5 data_cycle [*4])
		else $error("eight-beat burst cut short");
	a_chop_gap: assert property (rd_cmd ##0 !addr[A12_BIT] |->
		##5 data_cycle [*2] ##1 (!dq_oe && dqs_oe && dqs_o == DQS_LOW))
		else $error("chopped burst without gap");
	a_read_preamble: assert property ($rose(dqs_oe) |->
		(dqs_o == DQS_LOW && !dq_oe) ##1 data_cycle)
		else $error("strobe enabled without preamble");
	a_read_postamble: assert property ($fell(dq_oe) |->
		dqs_oe && dqs_o == DQS_LOW)
		else $error("data ended without postamble");
	a_float_after: assert property ($fell(dqs_oe) |->
		!dq_oe && $past(dqs_o) == DQS_LOW)
		else $error("strobe released while data driven");
	a_col_spacing: assert property (col_cmd |=>
		!(cmd_n == CMD_RD || cmd_n == CMD_WR) [*3])
		else $error("column commands closer than four clocks");
	a_read_to_write: assert property (rd_cmd |=> (cmd_n != CMD_WR) [*5])
		else $error("write too soon after read");
	a_read_to_pre: assert property (cmd_n == CMD_PRE |->
		!($past(cmd_n, 1) == CMD_RD && $past(ba, 1) == ba) &&
		!($past(cmd_n, 2) == CMD_RD && $past(ba, 2) == ba) &&
		!($past(cmd_n, 3) == CMD_RD && $past(ba, 3) == ba))
		else $error("precharge within four clocks of a read");
	a_zq_quiet: assert property (zq_left != 10'h000 |->
		cke && !odt && !dq_oe && (cmd_n == CMD_NOP || cmd_n == CMD_ZQ))
		else $error("channel activity during calibration");
endmodule
`default_nettype wire

// >>> dv/dram_zq_activate_read_cmds_tb_top.sv
// Bench joining the controller end and the DRAM end over the link
`timescale 1ns/100ps
`default_nettype none
module dram_zq_activate_read_cmds_tb_top;
	import ddr3_link_pkg::*;

	typedef struct packed {
		op_e              op;
		logic [BA_W-1:0]  bank;
		logic [A_W-1:0]   addr;
		logic             bc4;
		logic [2:0]       words;
		logic [NBANK-1:0] open_exp;
		logic             busy_exp;
		logic             long_exp;
	} row_s;

	logic              clock;
	logic              sys_rst;
	logic              req_valid;
	op_e               req_op;
	logic [BA_W-1:0]   req_bank;
	logic [A_W-1:0]    req_addr;
	logic              req_bc4;
	logic              req_ack;
	logic              rd_valid;
	logic [2*DQ_W-1:0] rd_data;
	logic [NBANK-1:0]  bank_open;
	logic              zq_busy;
	logic              zq_long;
	logic              proto_err;
	int                num_errors;
	int                n_tests;
	logic [15:0]       got[$];
	row_s              rows[10];

	ddr3_link_if link ();
	ddr3_ctrl_end ddr3_ctrl_end_inst (
		.clock (clock), .sys_rst (sys_rst), .link (link),
		.req_valid (req_valid), .req_op (req_op), .req_bank (req_bank),
		.req_addr (req_addr), .req_bc4 (req_bc4), .req_ack (req_ack),
		.rd_valid (rd_valid), .rd_data (rd_data)
	);
	ddr3_dram_end ddr3_dram_end_inst (
		.link (link), .sys_rst (sys_rst), .bank_open (bank_open),
		.zq_busy (zq_busy), .zq_long (zq_long), .proto_err (proto_err)
	);
	ddr3_link_monitor ddr3_link_monitor_inst (
		.sys_rst (sys_rst), .ck (link.ck), .cke (link.cke), .odt (link.odt),
		.cmd_n (link.cmd_n), .ba (link.ba), .addr (link.addr),
		.dq_o (link.dq_o), .dq_oe (link.dq_oe), .dqs_o (link.dqs_o),
		.dqs_oe (link.dqs_oe)
	);

	always #5 clock = ~clock;

	always @(posedge clock)
		if (rd_valid === 1'b1)
			got.push_back(rd_data);

	function automatic logic [7:0] beat(input logic [9:0] col,
		input logic [2:0] i);
		beat = {col[7:3], col[2] ^ i[2], col[1:0] + i[1:0]};
	endfunction

	task automatic final_report;
		if (num_errors == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk_word(input logic [15:0] exp, input logic [15:0] seen);
		n_tests++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH read word expected %h seen %h", exp, seen);
		end
	endtask

	task automatic chk_flags(input string what, input logic [7:0] exp,
		input logic [7:0] seen);
		n_tests++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Request held until acknowledged, dropped at the edge that sees it
	task automatic issue(input op_e op, input logic [BA_W-1:0] ba,
		input logic [A_W-1:0] a, input logic bc4);
		int n;
		@(posedge clock);
		req_valid <= 1'b1;
		req_op <= op;
		req_bank <= ba;
		req_addr <= a;
		req_bc4 <= bc4;
		n = 0;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (req_ack !== 1'b1 && n < 9000);
		req_valid <= 1'b0;
		chk_flags("req_ack", 8'h01, {7'h00, req_ack});
	endtask

	task automatic expect_reads(input logic [9:0] col, input logic [2:0] nw);
		int n;
		n = 0;
		while (got.size() < nw && n < 400)
		begin
			@(posedge clock);
			n++;
		end
		for (int c = 0; c < nw; c++)
			chk_word({beat(col, 3'(2*c+1)), beat(col, 3'(2*c))},
				got.size() > 0 ? got.pop_front() : 16'hXXXX);
	endtask

	task automatic chk_state(input logic [7:0] op, input logic bz,
		input logic lg);
		chk_flags("bank_open", op, bank_open);
		chk_flags("zq_busy", {7'h00, bz}, {7'h00, zq_busy});
		chk_flags("zq_long", {7'h00, lg}, {7'h00, zq_long});
	endtask

	initial
	begin
		repeat (40000) @(posedge clock);
		num_errors++;
		$display("MISMATCH watchdog expected done seen running");
		final_report();
	end

	initial
	begin
		clock = 1'b0;
		sys_rst = 1'b1;
		req_valid = 1'b0;
		req_op = OP_ACT;
		req_bank = 3'h0;
		req_addr = 14'h0000;
		req_bc4 = 1'b0;
		num_errors = 0;
		n_tests = 0;
		rows[0] = '{OP_ZQCL, 3'h0, 14'h0000, 1'b0, 3'h0, 8'h00, 1'b1, 1'b1};
		rows[1] = '{OP_ACT, 3'h1, 14'h0123, 1'b0, 3'h0, 8'h02, 1'b0, 1'b1};
		rows[2] = '{OP_ACT, 3'h6, 14'h2A5C, 1'b0, 3'h0, 8'h42, 1'b0, 1'b1};
		rows[3] = '{OP_RD, 3'h1, 14'h0015, 1'b0, 3'h4, 8'h42, 1'b0, 1'b1};
		rows[4] = '{OP_RD, 3'h6, 14'h03FE, 1'b1, 3'h2, 8'h42, 1'b0, 1'b1};
		rows[5] = '{OP_WR, 3'h1, 14'h0008, 1'b0, 3'h0, 8'h42, 1'b0, 1'b1};
		rows[6] = '{OP_PRE, 3'h1, 14'h0000, 1'b0, 3'h0, 8'h40, 1'b0, 1'b1};
		rows[7] = '{OP_RDA, 3'h6, 14'h0007, 1'b0, 3'h4, 8'h00, 1'b0, 1'b1};
		rows[8] = '{OP_ZQCS, 3'h0, 14'h0000, 1'b0, 3'h0, 8'h00, 1'b1, 1'b0};
		rows[9] = '{OP_ACT, 3'h0, 14'h1FFF, 1'b0, 3'h0, 8'h01, 1'b0, 1'b0};
		repeat (5) @(posedge clock);
		sys_rst <= 1'b0;
		// DRAM end leaves reset two CK rises later; earlier commands are lost
		repeat (24) @(posedge clock);
		foreach (rows[i])
		begin
			issue(rows[i].op, rows[i].bank, rows[i].addr, rows[i].bc4);
			expect_reads(rows[i].addr[9:0], rows[i].words);
			// Three CK periods: DRAM state lags the command by one CK
			repeat (36) @(posedge clock);
			chk_state(rows[i].open_exp, rows[i].busy_exp, rows[i].long_exp);
		end
		for (int k = 0; k < 2; k++)
		begin
			issue(OP_RD, 3'h0, 14'h0040, k[0]);
			issue(OP_RD, 3'h0, 14'h0085, k[0]);
			expect_reads(10'h040, k[0] ? 3'h2 : 3'h4);
			expect_reads(10'h085, k[0] ? 3'h2 : 3'h4);
		end
		issue(OP_RD, 3'h0, 14'h0011, 1'b0);
		issue(OP_WR, 3'h0, 14'h0000, 1'b0);
		issue(OP_PRE, 3'h0, 14'h0000, 1'b0);
		expect_reads(10'h011, 3'h4);
		repeat (36) @(posedge clock);
		chk_state(8'h00, 1'b0, 1'b0);
		chk_flags("proto_err", 8'h00, {7'h00, proto_err});
		issue(OP_ACT, 3'h2, 14'h0001, 1'b0);
		repeat (36) @(posedge clock);
		sys_rst <= 1'b1;
		repeat (3) @(posedge clock);
		chk_state(8'h00, 1'b0, 1'b0);
		chk_flags("cmd_n", {4'h0, CMD_NOP}, {4'h0, link.cmd_n});
		chk_flags("cke", 8'h00, {7'h00, link.cke});
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		repeat (24) @(posedge clock);
		issue(OP_ACT, 3'h3, 14'h0002, 1'b0);
		repeat (36) @(posedge clock);
		chk_state(8'h08, 1'b0, 1'b0);
		chk_flags("proto_err", 8'h00, {7'h00, proto_err});
		final_report();
	end
endmodule
`default_nettype wire

// >>> logic/ddr3_ctrl_end.sv
// Controller end: CK divider, command timing checks and read capture
`timescale 1ns/100ps
`default_nettype none
module ddr3_ctrl_end
(
	input  wire logic                           clock,
	input  wire logic                           sys_rst,
	ddr3_link_if.host                           link,
	input  wire logic                           req_valid,
	input  wire ddr3_link_pkg::op_e             req_op,
	input  wire logic [ddr3_link_pkg::BA_W-1:0] req_bank,
	input  wire logic [ddr3_link_pkg::A_W-1:0]  req_addr,
	input  wire logic                           req_bc4,
	output logic                                req_ack,
	output logic                                rd_valid,
	output logic [2*ddr3_link_pkg::DQ_W-1:0]    rd_data
);
	import ddr3_link_pkg::*;

	logic [DIV_W-1:0]    div;
	logic [DIV_W-1:0]    next_div;
	logic                slot;
	logic                ok;
	logic                issue;
	logic                is_zq_op;
	logic                is_rd_op;
	logic [3:0]          cmd_code;
	logic [A_W-1:0]      out_addr;
	logic [CNT_W-1:0]    rrd_c;
	logic [CNT_W-1:0]    ccd_c;
	logic [CNT_W-1:0]    rtw_c;
	logic [CNT_W-1:0]    zq_c;
	logic [1:0]          faw_ptr;
	logic [RD_SR_W-1:0]  sr_v;
	logic [RD_SR_W-1:0]  sr_bc;
	logic                cap;
	wire  [NBANK-1:0]    act_ok_w;
	wire  [NBANK-1:0]    rd_ok_w;
	wire  [NBANK-1:0]    pre_ok_w;
	wire  [NBANK-1:0]    idle_w;
	wire  [FAW_ACTS-1:0] faw_busy_w;

	function automatic logic [CNT_W-1:0] dec(input logic [CNT_W-1:0] v);
		return (v == '0) ? v : v - CNT_W'(1);
	endfunction

	// CK comes from the system clock; commands change as CK falls
	assign next_div = (div == CK_TOP) ? '0 : div + DIV_W'(1);
	assign slot     = next_div == CK_HALF;

	always_ff @(posedge clock or posedge sys_rst)
		if (sys_rst)
		begin
			div     <= '0;
			link.ck <= 1'b0;
		end
		else
		begin
			div     <= next_div;
			link.ck <= next_div < CK_HALF;
		end

	assign is_zq_op = req_op == OP_ZQCL || req_op == OP_ZQCS;
	assign is_rd_op = req_op == OP_RD || req_op == OP_RDA;

	// Legality of the pending request at the next command slot
	always_comb
	begin
		ok       = 1'b0;
		cmd_code = CMD_NOP;
		out_addr = req_addr;
		case (req_op)
			OP_ACT:
			begin
				ok = act_ok_w[req_bank] && rrd_c == '0 &&
					!faw_busy_w[faw_ptr];
				cmd_code = CMD_ACT;
			end
			OP_RD, OP_RDA:
			begin
				ok = rd_ok_w[req_bank] && ccd_c == '0;
				cmd_code = CMD_RD;
				out_addr[A10_BIT] = req_op == OP_RDA;
				out_addr[A12_BIT] = !req_bc4;
			end
			OP_WR:
			begin
				ok = rd_ok_w[req_bank] && ccd_c == '0 &&
					rtw_c == '0;
				cmd_code = CMD_WR;
				out_addr[A10_BIT] = 1'b0;
				out_addr[A12_BIT] = !req_bc4;
			end
			OP_PRE:
			begin
				ok = pre_ok_w[req_bank];
				cmd_code = CMD_PRE;
				out_addr[A10_BIT] = 1'b0;
			end
			OP_ZQCL, OP_ZQCS:
			begin
				ok = &idle_w;
				cmd_code = CMD_ZQ;
				out_addr[A10_BIT] = req_op == OP_ZQCL;
			end
			default:
				ok = 1'b0;
		endcase
		// Only further calibration may enter a calibration window
		if (zq_c != '0 && !is_zq_op)
			ok = 1'b0;
	end

	assign issue = slot && req_valid && ok;

	for (genvar b = 0; b < NBANK; b++)
	begin : g_bank
		logic             open_b;
		logic             hit;
		logic [CNT_W-1:0] rcd_c;
		logic [CNT_W-1:0] ras_c;
		logic [CNT_W-1:0] rp_c;
		logic [CNT_W-1:0] rc_c;
		logic [CNT_W-1:0] rtp_c;

		assign hit         = issue && req_bank == BA_W'(b);
		assign act_ok_w[b] = !open_b && rp_c == '0 && rc_c == '0;
		// Early read allowed once the remaining tRCD is covered by AL
		assign rd_ok_w[b]  = open_b && rcd_c <= CNT_W'(AL);
		assign pre_ok_w[b] = rtp_c == '0 && ras_c == '0;
		assign idle_w[b]   = !open_b && rp_c == '0;

		always_ff @(posedge clock or posedge sys_rst)
			if (sys_rst)
			begin
				open_b <= 1'b0;
				rcd_c  <= '0;
				ras_c  <= '0;
				rp_c   <= '0;
				rc_c   <= '0;
				rtp_c  <= '0;
			end
			else if (slot)
			begin
				rcd_c <= dec(rcd_c);
				ras_c <= dec(ras_c);
				rp_c  <= dec(rp_c);
				rc_c  <= dec(rc_c);
				rtp_c <= dec(rtp_c);
				if (hit && req_op == OP_ACT)
				begin
					open_b <= 1'b1;
					rcd_c  <= CNT_W'(T_RCD_CK);
					ras_c  <= CNT_W'(T_RAS_CK);
					rc_c   <= CNT_W'(T_RC_CK);
				end
				if (hit && is_rd_op)
					rtp_c <= CNT_W'(RD2PRE_CK);
				// Auto precharge closes the row once tRAS and AL+tRTP pass
				if (hit && req_op == OP_RDA)
				begin
					open_b <= 1'b0;
					rp_c   <= ((ras_c > CNT_W'(AP_CK)) ? ras_c :
						CNT_W'(AP_CK)) + CNT_W'(T_RP_CK);
				end
				if (hit && req_op == OP_PRE)
				begin
					open_b <= 1'b0;
					rp_c   <= CNT_W'(T_RP_CK);
				end
			end
	end

	// Four rolling windows; the oldest must expire before a new ACT
	for (genvar f = 0; f < FAW_ACTS; f++)
	begin : g_faw
		logic [CNT_W-1:0] win;

		assign faw_busy_w[f] = win != '0;

		always_ff @(posedge clock or posedge sys_rst)
			if (sys_rst)
				win <= '0;
			else if (slot && issue && req_op == OP_ACT && faw_ptr == 2'(f))
				win <= CNT_W'(T_FAW_CK);
			else if (slot)
				win <= dec(win);
	end

	always_ff @(posedge clock or posedge sys_rst)
		if (sys_rst)
		begin
			rrd_c   <= '0;
			ccd_c   <= '0;
			rtw_c   <= '0;
			zq_c    <= '0;
			faw_ptr <= '0;
		end
		else if (slot)
		begin
			rrd_c <= dec(rrd_c);
			ccd_c <= dec(ccd_c);
			rtw_c <= dec(rtw_c);
			zq_c  <= dec(zq_c);
			if (issue && req_op == OP_ACT)
			begin
				rrd_c   <= CNT_W'(T_RRD_CK);
				faw_ptr <= faw_ptr + 2'h1;
			end
			// Load one less: tCCD exactly, so BL8 reads run seamless
			if (issue && (is_rd_op || req_op == OP_WR))
				ccd_c <= CNT_W'(T_CCD_CK - 1);
			if (issue && is_rd_op)
				rtw_c <= CNT_W'(RTW_CK);
			// Long form always waits the init length: one rank, no SR exit
			if (issue && req_op == OP_ZQCL)
				zq_c <= ZQINIT_CK;
			else if (issue && req_op == OP_ZQCS)
				zq_c <= ZQCS_CK;
		end

	// Clock enable low in reset, then stays high; termination stays off throughout
	always_ff @(posedge clock or posedge sys_rst)
		if (sys_rst)
		begin
			link.cke   <= 1'b0;
			link.odt   <= 1'b0;
			link.cmd_n <= CMD_NOP;
			link.ba    <= '0;
			link.addr  <= '0;
			req_ack    <= 1'b0;
		end
		else
		begin
			link.cke <= 1'b1;
			link.odt <= 1'b0;
			req_ack  <= issue;
			if (slot)
			begin
				link.cmd_n <= issue ? cmd_code : CMD_NOP;
				if (issue)
				begin
					link.ba   <= req_bank;
					link.addr <= out_addr;
				end
			end
		end

	// Sample mid-cycle, half a CK after the DRAM end updated the data
	always_comb
	begin
		cap = 1'b0;
		for (int j = 0; j < 4; j++)
			if (sr_v[RL+j] && !(sr_bc[RL+j] && j >= 2))
				cap = 1'b1;
	end

	always_ff @(posedge clock or posedge sys_rst)
		if (sys_rst)
		begin
			sr_v     <= '0;
			sr_bc    <= '0;
			rd_valid <= 1'b0;
			rd_data  <= '0;
		end
		else
		begin
			rd_valid <= slot && cap;
			if (slot)
			begin
				sr_v  <= {sr_v[RD_SR_W-2:0], issue && is_rd_op};
				sr_bc <= {sr_bc[RD_SR_W-2:0], req_bc4};
				if (cap)
					rd_data <= link.dq_o;
			end
		end

endmodule
`default_nettype wire

// >>> logic/ddr3_dram_end.sv
// DRAM end: command decode, calibration, bank state and read bursts
`timescale 1ns/100ps
`default_nettype none
module ddr3_dram_end
(
	ddr3_link_if.dram                          link,
	input  wire logic                          sys_rst,
	output logic [ddr3_link_pkg::NBANK-1:0]    bank_open,
	output logic                               zq_busy,
	output logic                               zq_long,
	output logic                               proto_err
);
	import ddr3_link_pkg::*;

	logic [1:0]        rst_sync;
	logic              rst;
	logic [3:0]        cmd;
	logic              is_act;
	logic              is_rd;
	logic              is_wr;
	logic              is_pre;
	logic              is_zq;
	logic [CNT_W-1:0]  zq_cnt;
	logic [CNT_W-1:0]  next_zq_cnt;
	logic              zq_first;
	wire  [NBANK-1:0]  open_w;
	wire  [NBANK-1:0]  err_w;
	rd_slot_s          rd_pipe [RL];
	rd_slot_s          cur;
	rd_slot_s          next_cur;
	rd_state_e         state;
	rd_state_e         next_state;
	logic [1:0]        beat;
	logic [1:0]        next_beat;
	logic [1:0]        last_beat;

	// Release of reset is retimed onto CK; assertion stays asynchronous
	always_ff @(posedge link.ck or posedge sys_rst)
		if (sys_rst)
			rst_sync <= 2'h3;
		else
			rst_sync <= {rst_sync[0], 1'b0};
	assign rst = rst_sync[1];

	// Commands count only while clock enable is high
	assign cmd    = link.cke ? link.cmd_n : CMD_NOP;
	assign is_act = cmd == CMD_ACT;
	assign is_rd  = cmd == CMD_RD;
	assign is_wr  = cmd == CMD_WR;
	assign is_pre = cmd == CMD_PRE;
	assign is_zq  = cmd == CMD_ZQ;

	// A10 picks long or short; first long one gets the init length
	always_comb
	begin
		next_zq_cnt = (zq_cnt == '0) ? zq_cnt : zq_cnt - CNT_W'(1);
		if (is_zq && link.addr[A10_BIT])
			next_zq_cnt = zq_first ? ZQINIT_CK : ZQOPER_CK;
		else if (is_zq)
			next_zq_cnt = ZQCS_CK;
	end

	// Not gated by any DLL state, so calibration overlaps DLL locking
	always_ff @(posedge link.ck or posedge rst)
		if (rst)
		begin
			zq_cnt   <= '0;
			zq_first <= 1'b1;
			zq_busy  <= 1'b0;
			zq_long  <= 1'b0;
		end
		else
		begin
			zq_cnt  <= next_zq_cnt;
			zq_busy <= next_zq_cnt != '0;
			if (is_zq)
				zq_long <= link.addr[A10_BIT];
			if (is_zq && link.addr[A10_BIT])
				zq_first <= 1'b0;
		end

	for (genvar b = 0; b < NBANK; b++)
	begin : g_bank
		logic             open_b;
		logic             ap_b;
		logic             hit;
		logic [CNT_W-1:0] ras_b;
		logic [CNT_W-1:0] ap_cnt;

		assign hit       = link.ba == BA_W'(b);
		assign open_w[b] = open_b;
		assign err_w[b]  = hit && (((is_rd || is_wr) && !open_b) ||
			(is_act && open_b));

		always_ff @(posedge link.ck or posedge rst)
			if (rst)
			begin
				open_b <= 1'b0;
				ap_b   <= 1'b0;
				ras_b  <= '0;
				ap_cnt <= '0;
			end
			else
			begin
				if (ras_b != '0)
					ras_b <= ras_b - CNT_W'(1);
				if (ap_b && ap_cnt != '0)
					ap_cnt <= ap_cnt - CNT_W'(1);
				// Internal precharge waits for both its delay and tRAS
				if (ap_b && ap_cnt == '0 && ras_b == '0)
				begin
					open_b <= 1'b0;
					ap_b   <= 1'b0;
				end
				if (is_act && hit)
				begin
					open_b <= 1'b1;
					ras_b  <= CNT_W'(T_RAS_CK);
				end
				else if (is_pre && (hit || link.addr[A10_BIT]))
				begin
					open_b <= 1'b0;
					ap_b   <= 1'b0;
				end
				else if (is_rd && hit && open_b && link.addr[A10_BIT])
				begin
					ap_b   <= 1'b1;
					ap_cnt <= CNT_W'(AP_CK - 1);
				end
			end
	end

	always_ff @(posedge link.ck or posedge rst)
		if (rst)
		begin
			bank_open <= '0;
			proto_err <= 1'b0;
		end
		else
		begin
			bank_open <= open_w;
			if ((|err_w) || (zq_cnt != '0 && cmd != CMD_NOP && !is_zq))
				proto_err <= 1'b1;
		end

	// Read latency counts from the command, so AL absorbs early reads
	always_ff @(posedge link.ck or posedge rst)
		if (rst)
		begin
			for (int i = 0; i < RL; i++)
				rd_pipe[i] <= '0;
		end
		else
		begin
			rd_pipe[0].v   <= is_rd;
			rd_pipe[0].bc4 <= !link.addr[A12_BIT];
			rd_pipe[0].col <= link.addr[COL_W-1:0];
			for (int i = 1; i < RL; i++)
				rd_pipe[i] <= rd_pipe[i-1];
		end

	function automatic logic [DQ_W-1:0] beat_val(input rd_slot_s s,
		input logic [2:0] i);
		logic [2:0] o;
		o = {s.col[2] ^ i[2], s.col[1:0] + i[1:0]};
		return {s.col[DQ_W-1:3], o};
	endfunction

	assign last_beat = cur.bc4 ? 2'h1 : 2'h3;

	// A new start always wins: a read leaving the pipe restarts at beat 0, even mid-burst
	always_comb
	begin
		next_state = RS_IDLE;
		next_beat  = beat;
		next_cur   = cur;
		if (rd_pipe[RL-1].v)
		begin
			next_state = RS_DATA;
			next_beat  = '0;
			next_cur   = rd_pipe[RL-1];
		end
		else if (state == RS_DATA && beat != last_beat)
		begin
			next_state = RS_DATA;
			next_beat  = beat + 2'h1;
		end
		else if (state == RS_DATA)
			next_state = RS_POST;
		else if (rd_pipe[RL-2].v)
			next_state = RS_PRE;
	end

	always_ff @(posedge link.ck or posedge rst)
		if (rst)
		begin
			state       <= RS_IDLE;
			beat        <= '0;
			cur         <= '0;
			link.dq_o   <= '0;
			link.dq_oe  <= 1'b0;
			link.dqs_o  <= DQS_LOW;
			link.dqs_oe <= 1'b0;
		end
		else
		begin
			state       <= next_state;
			beat        <= next_beat;
			cur         <= next_cur;
			link.dq_oe  <= next_state == RS_DATA;
			link.dqs_oe <= next_state != RS_IDLE;
			link.dqs_o  <= (next_state == RS_DATA) ? DQS_DATA : DQS_LOW;
			link.dq_o   <= {beat_val(next_cur, {next_beat, 1'b1}),
				beat_val(next_cur, {next_beat, 1'b0})};
		end

endmodule
`default_nettype wire

// >>> logic/ddr3_link_if.sv
// Pin-level link joining the DDR3 controller end and the DRAM end
`timescale 1ns/100ps
`default_nettype none
interface ddr3_link_if;
	import ddr3_link_pkg::*;

	logic                ck;
	logic                cke;
	logic                odt;
	logic [3:0]          cmd_n;
	logic [BA_W-1:0]     ba;
	logic [A_W-1:0]      addr;
	logic [2*DQ_W-1:0]   dq_o;
	logic                dq_oe;
	logic [1:0]          dqs_o;
	logic                dqs_oe;

	// Floating pins are shown by the enables; the complement is ~dqs_o
	modport host (
		output ck, cke, odt, cmd_n, ba, addr,
		input  dq_o, dq_oe, dqs_o, dqs_oe
	);
	modport dram (
		input  ck, cke, odt, cmd_n, ba, addr,
		output dq_o, dq_oe, dqs_o, dqs_oe
	);
endinterface
`default_nettype wire

// >>> logic/ddr3_link_pkg.sv
// Shared constants and types for both ends of the DDR3 command link
//
// Function
// - Calibrate only with all banks precharged, tRP met
// - Channel quiet during calibration except more calibration
// - Device accepts long and short calibration commands
// - Controller issues long calibration after self-refresh exit
// - Calibration may overlap DLL reset and locking
// - Two ranks never overlap calibration windows
// - Clock enable held high throughout calibration
// - Termination off and bus idle during calibration
// - Activate a row before reading or writing it
// - Early access allowed when spacing plus AL meets tRCD
// - Timing minimums round up to whole clock cycles
// - Reads and writes spaced at least tCCD apart
// - Precharge before reactivating; same-bank activations tRC apart
// - Different-bank activations at least tRRD apart
// - At most four activations per rolling tFAW window
// - First read data RL equals AL plus CL
// - Read beats follow on both clock edges, in order
// - Strobe preamble and postamble, data floats after burst
// - tCCD-spaced reads seamless; chop leaves gap; no truncation
// - Read to write at least RL+tCCD-WL+2 cycles
// - Precharge after read: four clocks and tRTP after AL
// - Auto precharge after AL+tRTP, held off by tRAS
package ddr3_link_pkg;

	localparam int NBANK = 8;
	localparam int BA_W  = 3;
	localparam int A_W   = 14;
	localparam int DQ_W  = 8;
	localparam int CNT_W = 10;
	localparam int DIV_W = 4;
	localparam int COL_W = 10;

	localparam int SYS_PERIOD_PS = 10000;
	localparam int CK_HALF_SYS   = 6;
	localparam int CK_PERIOD_PS  = 2 * CK_HALF_SYS * SYS_PERIOD_PS;
	localparam logic [DIV_W-1:0] CK_HALF = DIV_W'(CK_HALF_SYS);
	localparam logic [DIV_W-1:0] CK_TOP  = DIV_W'(2 * CK_HALF_SYS - 1);

	localparam int T_RCD_PS = 13750;
	localparam int T_RP_PS  = 13750;
	localparam int T_RC_PS  = 48750;
	localparam int T_RAS_PS = 35000;
	localparam int T_RRD_PS = 7500;
	localparam int T_FAW_PS = 40000;
	localparam int T_RTP_PS = 7500;

	// Round every minimum up to whole CK cycles
	localparam int T_RCD_CK = (T_RCD_PS + CK_PERIOD_PS - 1) / CK_PERIOD_PS;
	localparam int T_RP_CK  = (T_RP_PS + CK_PERIOD_PS - 1) / CK_PERIOD_PS;
	localparam int T_RC_CK  = (T_RC_PS + CK_PERIOD_PS - 1) / CK_PERIOD_PS;
	localparam int T_RAS_CK = (T_RAS_PS + CK_PERIOD_PS - 1) / CK_PERIOD_PS;
	localparam int T_RRD_CK = (T_RRD_PS + CK_PERIOD_PS - 1) / CK_PERIOD_PS;
	localparam int T_FAW_CK = (T_FAW_PS + CK_PERIOD_PS - 1) / CK_PERIOD_PS;
	localparam int T_RTP_CK = (T_RTP_PS + CK_PERIOD_PS - 1) / CK_PERIOD_PS;

	localparam int AL         = 0;
	localparam int CL         = 5;
	localparam int CWL        = 5;
	localparam int RL         = AL + CL;
	localparam int WL         = AL + CWL;
	localparam int T_CCD_CK   = 4;
	localparam int FAW_ACTS   = 4;
	localparam int RD2PRE_MIN = 4;
	localparam int RTW_CK     = RL + T_CCD_CK - WL + 2;
	localparam int RD2PRE_CK  = (AL + T_RTP_CK > RD2PRE_MIN) ?
		AL + T_RTP_CK : RD2PRE_MIN;
	localparam int AP_CK      = AL + ((T_RTP_CK > RD2PRE_MIN) ?
		T_RTP_CK : RD2PRE_MIN);
	localparam int RD_SR_W    = RL + 4;

	localparam logic [CNT_W-1:0] ZQINIT_CK = 10'h200;
	localparam logic [CNT_W-1:0] ZQOPER_CK = 10'h100;
	localparam logic [CNT_W-1:0] ZQCS_CK   = 10'h040;

	localparam int A10_BIT = 10;
	localparam int A12_BIT = 12;

	// Command bus order: cs_n, ras_n, cas_n, we_n
	localparam logic [3:0] CMD_ACT = 4'h3;
	localparam logic [3:0] CMD_RD  = 4'h5;
	localparam logic [3:0] CMD_WR  = 4'h4;
	localparam logic [3:0] CMD_PRE = 4'h2;
	localparam logic [3:0] CMD_ZQ  = 4'h6;
	localparam logic [3:0] CMD_NOP = 4'h7;

	localparam logic [1:0] DQS_DATA = 2'h2;
	localparam logic [1:0] DQS_LOW  = 2'h0;

	typedef enum logic [2:0] {
		OP_ACT  = 3'b000,
		OP_RD   = 3'b001,
		OP_RDA  = 3'b010,
		OP_WR   = 3'b011,
		OP_PRE  = 3'b100,
		OP_ZQCL = 3'b101,
		OP_ZQCS = 3'b110
	} op_e;

	typedef enum logic [1:0] {
		RS_IDLE = 2'b00,
		RS_PRE  = 2'b01,
		RS_DATA = 2'b10,
		RS_POST = 2'b11
	} rd_state_e;

	typedef struct packed {
		logic             v;
		logic             bc4;
		logic [COL_W-1:0] col;
	} rd_slot_s;

endpackage
